/* File: inc/iommu_defs.vh */
// Constants for the paravirtual IOMMU attach/detach request handler
`ifndef IOMMU_DEFS_VH
`define IOMMU_DEFS_VH

// Request type byte values
`define REQ_TYPE_ATTACH     8'h01
`define REQ_TYPE_DETACH     8'h02

// Tail status byte values
`define STS_OK              8'h00
`define STS_UNSUPP          8'h02
`define STS_INVAL           8'h04
`define STS_NOENT           8'h06

// Byte offsets inside the device-readable part
`define OFS_TYPE            5'h00
`define OFS_DOMAIN          5'h04
`define OFS_ENDPOINT        5'h08
`define OFS_FLAGS           5'h0c
`define OFS_ATT_RESV        5'h10
`define READ_PART_LEN       5'h14

// Device-writable tail length and used length when no tail is written
`define TAIL_LEN            8'h04
`define USED_NONE           8'h00

// Attach flag bit positions
`define ATT_FLAG_BYPASS     0

// Table sizes
`define NUM_EP              8
`define EP_IDX_W            3
`define NUM_DOM             8
`define DOM_IDX_W           3
`define DOM_CNT_W           4
`define EP_CLASS_W          2

`endif

/* File: rtl/req_field_collector.v */
// Collects a request's readable bytes into little-endian fields
`include "iommu_defs.vh"

module req_field_collector (
    input  wire        clk,
    input  wire        rst,
    input  wire        byteValid,
    input  wire [7:0]  byteData,
    input  wire        byteLast,
    output reg         fieldsValid,
    output reg  [7:0]  reqType,
    output reg  [31:0] reqDomain,
    output reg  [31:0] reqEndpoint,
    output reg  [31:0] reqFlags,
    output reg         attResvNz,
    output reg         longEnough
);

    reg [4:0] byteCnt_r;
    wire      inBody = (byteCnt_r < `READ_PART_LEN);
    wire [1:0] lane = byteCnt_r[1:0];

    // Byte placement; head reserved bytes are simply never stored
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            byteCnt_r   <= 5'h00;
            fieldsValid <= 1'b0;
            reqType     <= 8'h00;
            reqDomain   <= 32'h0;
            reqEndpoint <= 32'h0;
            reqFlags    <= 32'h0;
            attResvNz   <= 1'b0;
            longEnough  <= 1'b0;
        end else begin
            fieldsValid <= byteValid & byteLast;
            if (byteValid) begin
                if (byteLast) begin
                    byteCnt_r  <= 5'h00;
                    // Trailing bytes beyond the known layout are tolerated
                    longEnough <= (byteCnt_r >= (`READ_PART_LEN - 5'h01));
                end else if (inBody) begin
                    byteCnt_r <= byteCnt_r + 5'h01;
                end
                if (byteCnt_r == 5'h00) begin
                    reqType   <= byteData;
                    attResvNz <= 1'b0;
                end
                if (inBody) begin
                    // Little-endian: lowest address lands in the low byte
                    case (byteCnt_r[4:2])
                        3'h1: reqDomain[lane*8 +: 8]   <= byteData;
                        3'h2: reqEndpoint[lane*8 +: 8] <= byteData;
                        3'h3: reqFlags[lane*8 +: 8]    <= byteData;
                        3'h4: attResvNz <= attResvNz | (|byteData);
                        default: ;
                    endcase
                end
            end
        end
    end

endmodule // req_field_collector

/* File: rtl/endpoint_access_check.v */
// Grants (identity), blocks or sends to translation one endpoint access per cycle
`include "iommu_defs.vh"

module endpoint_access_check (
    input  wire                  clk,
    input  wire                  rst,
    input  wire                  accValid,
    input  wire [63:0]           accAddr,
    input  wire                  epAttached,
    input  wire                  domBypass,
    input  wire [31:0]           domId,
    input  wire                  unattBypass,
    output reg                   accDone,
    output reg                   accGrant,
    output reg                   accBypass,
    output reg                   accXlate,
    output reg  [31:0]           accDomain,
    output reg  [63:0]           accAddrOut
);

    wire byp = epAttached ? domBypass : unattBypass;

    // Attached non-bypass endpoints go to translation with their domain only
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            accDone    <= 1'b0;
            accGrant   <= 1'b0;
            accBypass  <= 1'b0;
            accXlate   <= 1'b0;
            accDomain  <= 32'h0;
            accAddrOut <= 64'h0;
        end else begin
            accDone    <= accValid;
            accGrant   <= accValid & byp;
            accBypass  <= accValid & byp;
            accXlate   <= accValid & epAttached & ~domBypass;
            accDomain  <= (epAttached & ~domBypass) ? domId : 32'h0;
            // Identity translation; blocked accesses show no address
            accAddrOut <= (accValid & (byp | epAttached)) ? accAddr : 64'h0;
        end
    end

endmodule // endpoint_access_check

/* File: rtl/iommu_attach_detach_handler.v */
// Attach/detach request handler with endpoint and domain tables
`include "iommu_defs.vh"

module iommu_attach_detach_handler (
    input  wire                                clk,
    input  wire                                rst,
    input  wire                                reqByteValid,
    input  wire [7:0]                          reqByte,
    input  wire                                reqByteLast,
    input  wire [7:0]                          reqWrLen,
    output reg                                 reqReady,
    output reg                                 respValid,
    output reg                                 respTailWritten,
    output reg  [7:0]                          respUsedLen,
    output reg  [31:0]                         respTail,
    input  wire                                featBypassCfg,
    input  wire                                cfgBypass,
    input  wire                                featBypassLegacy,
    input  wire [`NUM_EP*`EP_CLASS_W-1:0]      epClass,
    input  wire                                accValid,
    input  wire [`EP_IDX_W-1:0]                accEp,
    input  wire [63:0]                         accAddr,
    output wire                                accDone,
    output wire                                accGrant,
    output wire                                accBypass,
    output wire                                accXlate,
    output wire [31:0]                         accDomain,
    output wire [63:0]                         accAddrOut,
    output reg  [`NUM_EP-1:0]                  epAttachedMap
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_EXEC = 3'b010;
    localparam [2:0] ST_RESP = 3'b100;

    reg  [2:0]                 state_r;
    reg  [2:0]                 state_nxt;

    // Endpoint table: which slot each endpoint sits in
    reg  [`DOM_IDX_W-1:0]      epSlot_r [0:`NUM_EP-1];
    // Domain slot table
    reg  [`NUM_DOM-1:0]        domValid_r;
    reg  [`NUM_DOM-1:0]        domByp_r;
    reg  [31:0]                domId_r   [0:`NUM_DOM-1];
    reg  [`DOM_CNT_W-1:0]      domCnt_r  [0:`NUM_DOM-1];
    reg  [`EP_CLASS_W-1:0]     domCls_r  [0:`NUM_DOM-1];

    wire                       fieldsValid;
    wire [7:0]                 reqType;
    wire [31:0]                reqDomain;
    wire [31:0]                reqEndpoint;
    wire [31:0]                reqFlags;
    wire                       attResvNz;
    wire                       longEnough;

    req_field_collector u_collect (
        .clk         (clk),
        .rst         (rst),
        .byteValid   (reqByteValid & reqReady),
        .byteData    (reqByte),
        .byteLast    (reqByteLast),
        .fieldsValid (fieldsValid),
        .reqType     (reqType),
        .reqDomain   (reqDomain),
        .reqEndpoint (reqEndpoint),
        .reqFlags    (reqFlags),
        .attResvNz   (attResvNz),
        .longEnough  (longEnough)
    );

    // Domain ID lookup, one comparator per slot
    wire [`NUM_DOM-1:0] domHit;
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_DOM; gi = gi + 1) begin : g_hit
            assign domHit[gi] = domValid_r[gi] & (domId_r[gi] == reqDomain);
        end
    endgenerate

    // Encoders for the hit slot and the lowest free slot
    reg  [`DOM_IDX_W-1:0] hitSlot;
    reg  [`DOM_IDX_W-1:0] freeSlot;
    reg                   freeFound;
    integer k;
    always @* begin
        hitSlot   = {`DOM_IDX_W{1'b0}};
        freeSlot  = {`DOM_IDX_W{1'b0}};
        freeFound = 1'b0;
        for (k = `NUM_DOM - 1; k >= 0; k = k - 1) begin
            if (domHit[k]) begin
                hitSlot = k[`DOM_IDX_W-1:0];
            end
            if (!domValid_r[k]) begin
                freeSlot  = k[`DOM_IDX_W-1:0];
                freeFound = 1'b1;
            end
        end
    end

    wire                    epExists = (reqEndpoint < `NUM_EP);
    wire [`EP_IDX_W-1:0]    epIdx    = reqEndpoint[`EP_IDX_W-1:0];
    wire                    epAtt    = epAttachedMap[epIdx];
    wire [`DOM_IDX_W-1:0]   oldSlot  = epSlot_r[epIdx];
    wire                    domExist = |domHit;
    wire [`EP_CLASS_W-1:0]  myClass  = epClass[epIdx*`EP_CLASS_W +: `EP_CLASS_W];
    wire [31:0]             flagMask = {31'h0, featBypassCfg};
    wire                    reqByp   = featBypassCfg & reqFlags[`ATT_FLAG_BYPASS];
    // Moving out of a sole-member domain frees its slot for reuse at once
    wire                    oldFrees = epAtt & (domCnt_r[oldSlot] == 4'h1);
    wire [`DOM_IDX_W-1:0]   newSlot  = domExist ? hitSlot : (freeFound ? freeSlot : oldSlot);
    wire                    canMake  = domExist | freeFound | oldFrees;

    // Request decision
    reg  [7:0] status;
    reg        doAttach;
    reg        doDetach;
    reg        tailOk;
    always @* begin
        status   = `STS_OK;
        doAttach = 1'b0;
        doDetach = 1'b0;
        // Tail can only be located if both parts cover the known layout
        tailOk   = longEnough & (reqWrLen >= `TAIL_LEN);
        if (reqType == `REQ_TYPE_ATTACH) begin
            if (attResvNz) begin
                status = `STS_INVAL;
            end else if (|(reqFlags & ~flagMask)) begin
                status = `STS_INVAL;
            end else if (!epExists) begin
                status = `STS_NOENT;
            end else if (domExist && (domByp_r[hitSlot] != reqByp)) begin
                status = `STS_INVAL;
            end else if (domExist && (domCnt_r[hitSlot] != 4'h0) &&
                         (domCls_r[hitSlot] != myClass)) begin
                status = `STS_UNSUPP;
            end else if (domExist && (&domCnt_r[hitSlot])) begin
                status = `STS_UNSUPP;
            end else if (!canMake) begin
                status = `STS_UNSUPP;
            end else begin
                doAttach = 1'b1;
            end
        end else if (reqType == `REQ_TYPE_DETACH) begin
            // Detach reserved bytes are never examined
            if (!epExists) begin
                status = `STS_NOENT;
            end else if (!domExist || !epAtt || (oldSlot != hitSlot)) begin
                status = `STS_INVAL;
            end else begin
                doDetach = 1'b1;
            end
        end else begin
            tailOk = 1'b0;
        end
        // Nothing changes unless the answer can be delivered
        if (!tailOk) begin
            doAttach = 1'b0;
            doDetach = 1'b0;
        end
    end

    // Whether the endpoint really leaves its old slot on this request
    // A reused sole-member slot must still take the new identity, so it is not a no-op
    wire sameSlot = doAttach & epAtt & domExist & (oldSlot == newSlot);
    wire leaveOld = (doDetach | (doAttach & epAtt)) & ~sameSlot;

    // Per-slot table update; counts fall before they rise on a move
    generate
        for (gi = 0; gi < `NUM_DOM; gi = gi + 1) begin : g_dom
            wire dec = leaveOld & (oldSlot == gi);
            wire inc = doAttach & ~sameSlot & (newSlot == gi);
            wire [`DOM_CNT_W-1:0] cntAfter = domCnt_r[gi] - {3'h0, dec};
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    domValid_r[gi] <= 1'b0;
                    domByp_r[gi]   <= 1'b0;
                    domId_r[gi]    <= 32'h0;
                    domCnt_r[gi]   <= 4'h0;
                    domCls_r[gi]   <= 2'h0;
                end else if (state_r == ST_EXEC) begin
                    if (inc) begin
                        if (cntAfter == 4'h0) begin
                            // Fresh or reused slot takes the new domain's identity
                            domValid_r[gi] <= 1'b1;
                            domId_r[gi]    <= reqDomain;
                            domByp_r[gi]   <= reqByp;
                            domCls_r[gi]   <= myClass;
                        end
                        domCnt_r[gi] <= cntAfter + 4'h1;
                    end else if (dec) begin
                        domCnt_r[gi] <= cntAfter;
                        if (cntAfter == 4'h0) begin
                            domValid_r[gi] <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate

    // Endpoint table update; one slot index per endpoint keeps it in one domain
    generate
        for (gi = 0; gi < `NUM_EP; gi = gi + 1) begin : g_ep
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    epAttachedMap[gi] <= 1'b0;
                    epSlot_r[gi]      <= {`DOM_IDX_W{1'b0}};
                end else if ((state_r == ST_EXEC) && (epIdx == gi)) begin
                    if (doAttach) begin
                        epAttachedMap[gi] <= 1'b1;
                        epSlot_r[gi]      <= newSlot;
                    end else if (doDetach) begin
                        epAttachedMap[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Sequencer: one request at a time, bytes refused while busy
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (fieldsValid) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: state_nxt = ST_RESP;
            ST_RESP: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r  <= ST_IDLE;
            reqReady <= 1'b1;
        end else begin
            state_r  <= state_nxt;
            reqReady <= (state_nxt == ST_IDLE) & ~(reqByteValid & reqReady & reqByteLast);
        end
    end

    // Response; tail reserved bytes always zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            respValid       <= 1'b0;
            respTailWritten <= 1'b0;
            respUsedLen     <= `USED_NONE;
            respTail        <= 32'h0;
        end else begin
            respValid <= (state_r == ST_EXEC);
            if (state_r == ST_EXEC) begin
                respTailWritten <= tailOk;
                respUsedLen     <= tailOk ? `TAIL_LEN : `USED_NONE;
                respTail        <= tailOk ? {24'h0, status} : 32'h0;
            end
        end
    end

    // Access path sees the table of the queried endpoint
    wire [`DOM_IDX_W-1:0] accSlot     = epSlot_r[accEp];
    // Unattached endpoints pass only under a bypass feature
    wire                  unattBypass = (featBypassCfg & cfgBypass) | featBypassLegacy;

    endpoint_access_check u_access (
        .clk         (clk),
        .rst         (rst),
        .accValid    (accValid),
        .accAddr     (accAddr),
        .epAttached  (epAttachedMap[accEp]),
        .domBypass   (domByp_r[accSlot]),
        .domId       (domId_r[accSlot]),
        .unattBypass (unattBypass),
        .accDone     (accDone),
        .accGrant    (accGrant),
        .accBypass   (accBypass),
        .accXlate    (accXlate),
        .accDomain   (accDomain),
        .accAddrOut  (accAddrOut)
    );

endmodule // iommu_attach_detach_handler

/* File: testbench/iommu_handler_properties.sv */
// Timing and value checks on the attach/detach handler's ports
module iommu_handler_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        reqByteValid,
    input wire logic        reqByteLast,
    input wire logic        reqReady,
    input wire logic        respValid,
    input wire logic        respTailWritten,
    input wire logic [7:0]  respUsedLen,
    input wire logic [31:0] respTail,
    input wire logic        accValid,
    input wire logic [63:0] accAddr,
    input wire logic        accDone,
    input wire logic        accGrant,
    input wire logic        accXlate,
    input wire logic [31:0] accDomain,
    input wire logic [63:0] accAddrOut,
    input wire logic [7:0]  epAttachedMap
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Request side: busy window and a single answer pulse
    property p_busy;
        reqByteValid && reqReady && reqByteLast |=> !reqReady[*3] ##1 reqReady;
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready not held low for the answer");
    property p_answer;
        reqByteValid && reqReady && reqByteLast |-> ##3 respValid ##1 !respValid;
    endproperty
    a_answer: assert property (p_answer)
        else $error("answer not a pulse three cycles on");
    property p_used;
        respValid |-> respUsedLen == (respTailWritten ? 8'h04 : 8'h00);
    endproperty
    a_used: assert property (p_used)
        else $error("used length disagrees with tail");
    property p_resv;
        respValid |-> respTail[31:8] == 24'h0;
    endproperty
    a_resv: assert property (p_resv)
        else $error("tail reserved bytes not zero");
    property p_code;
        respValid && respTailWritten |-> respTail[7:0] inside {8'h0, 8'h2, 8'h4, 8'h6};
    endproperty
    a_code: assert property (p_code)
        else $error("unknown status code");
    property p_blank;
        respValid && !respTailWritten |-> respTail == 32'h0;
    endproperty
    a_blank: assert property (p_blank)
        else $error("unwritten answer carries data");
    // Table only moves when a request is answered
    property p_map;
        !respValid |-> $stable(epAttachedMap);
    endproperty
    a_map: assert property (p_map)
        else $error("binding changed outside an answer");

    // Access side: one-cycle answer that also holds for back-to-back queries
    property p_acc;
        accDone == $past(accValid);
    endproperty
    a_acc: assert property (p_acc)
        else $error("access answer missing or extra");
    property p_block;
        accDone && !accGrant && !accXlate |-> accAddrOut == 64'h0 && accDomain == 32'h0;
    endproperty
    a_block: assert property (p_block)
        else $error("blocked access leaked");
    property p_ident;
        accDone && accGrant |-> !accXlate && accAddrOut == $past(accAddr);
    endproperty
    a_ident: assert property (p_ident)
        else $error("bypass not identity");
endmodule // iommu_handler_checker

bind iommu_attach_detach_handler iommu_handler_checker iommu_handler_checker_inst (.*);

/* File: testbench/guest_driver_model.sv */
// Guest driver model that sends one request at a time, byte by byte
module guest_driver_model (
    input  wire logic clk,
    input  wire logic reqReady,
    input  wire logic respValid,
    output logic      reqByteValid,
    output logic [7:0] reqByte,
    output logic      reqByteLast,
    output logic [7:0] reqWrLen
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reqByteValid = 1'b0;
        reqByte      = 8'h00;
        reqByteLast  = 1'b0;
        reqWrLen     = 8'h04;
    end

    // Writable part size for the requests that follow
    task automatic setWrLen(input logic [7:0] v);
        reqWrLen <= v;
    endtask

    // Range features are never negotiated, so any domain value is legal
    task automatic sendReq(input logic [7:0] typ, input logic [31:0] dom, ep, flags, resv,
                           input int n, output logic got);
        logic [7:0] b [0:19];
        int         i;
        int         w;
        b[0] = typ;
        for (i = 1; i < 4; i++) b[i] = 8'ha5; // Head reserved bytes nonzero on purpose
        // Little-endian body words
        for (i = 0; i < 4; i++) begin
            b[4 + i]  = dom[8 * i +: 8];
            b[8 + i]  = ep[8 * i +: 8];
            b[12 + i] = flags[8 * i +: 8];
            b[16 + i] = resv[8 * i +: 8];
        end
        // Hold each byte until an edge sees ready high
        for (i = 0; i < n; i++) begin
            reqByteValid <= 1'b1;
            reqByte      <= b[i];
            reqByteLast  <= (i == n - 1);
            w = 0;
            do @(posedge clk); while (!reqReady && ++w < 50);
        end
        reqByteValid <= 1'b0;
        reqByteLast  <= 1'b0;
        reqByte      <= ~b[n - 1]; // Released line must not keep the last value
        got = 1'b0;
        for (w = 0; w < 10 && !got; w++) begin
            @(posedge clk);
            got = respValid;
        end
    endtask
endmodule // guest_driver_model

/* File: testbench/test_iommu_attach_detach_handler.sv */
// Self-checking bench for the attach/detach request handler
`include "iommu_defs.vh"
module test_iommu_attach_detach_handler;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, reqByteValid, reqByteLast, reqReady, respValid;
    logic        respTailWritten, featBypassCfg = 1'b0, cfgBypass = 1'b0, featBypassLegacy = 1'b0;
    logic [7:0]  reqByte, reqWrLen, respUsedLen, epAttachedMap;
    logic [31:0] respTail, accDomain;
    logic [15:0] epClass = 16'h0040; // Endpoint 3 alone has another class
    logic        accValid = 1'b0, accDone, accGrant, accBypass, accXlate;
    logic [2:0]  accEp = 3'h0;
    logic [63:0] accAddr = 64'h0, accAddrOut;
    int          badCount = 0, comparisons = 0, cycles = 0;

    iommu_attach_detach_handler iommu_attach_detach_handler_inst (
        .clk(clk), .rst(rst), .reqByteValid(reqByteValid), .reqByte(reqByte),
        .reqByteLast(reqByteLast), .reqWrLen(reqWrLen), .reqReady(reqReady),
        .respValid(respValid), .respTailWritten(respTailWritten), .respUsedLen(respUsedLen),
        .respTail(respTail), .featBypassCfg(featBypassCfg), .cfgBypass(cfgBypass),
        .featBypassLegacy(featBypassLegacy), .epClass(epClass), .accValid(accValid),
        .accEp(accEp), .accAddr(accAddr), .accDone(accDone), .accGrant(accGrant),
        .accBypass(accBypass), .accXlate(accXlate), .accDomain(accDomain),
        .accAddrOut(accAddrOut), .epAttachedMap(epAttachedMap));
    guest_driver_model guest_driver_model_inst (
        .clk(clk), .reqReady(reqReady), .respValid(respValid), .reqByteValid(reqByteValid),
        .reqByte(reqByte), .reqByteLast(reqByteLast), .reqWrLen(reqWrLen));

    always #50 clk = ~clk;
    // Run needs about 500 cycles; a hang ends here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            badCount++;
            giveVerdict();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic req(input logic [7:0] typ, input logic [31:0] dom, ep, flags, resv,
                       input int n, input logic [7:0] sts, input logic wr);
        logic got;
        guest_driver_model_inst.sendReq(typ, dom, ep, flags, resv, n, got);
        check(got, 1'b1);
        check(respTailWritten, wr);
        check(respUsedLen, wr ? `TAIL_LEN : `USED_NONE);
        check(respTail, wr ? {24'h0, sts} : 32'h0);
    endtask
    // One access; expected address is the one sent when passed on
    task automatic acc(input logic [2:0] ep, input logic g, x, input logic [31:0] d);
        accValid <= 1'b1;
        accEp    <= ep;
        accAddr  <= {32'hcafe_0000, 29'h0, ep};
        @(posedge clk);
        accValid <= 1'b0;
        @(posedge clk);
        check(accDone, 1'b1);
        check({accGrant, accBypass, accXlate}, {g, g, x});
        check(accDomain, x ? d : 32'h0);
        check(accAddrOut, (g | x) ? accAddr : 64'h0);
    endtask
    task automatic giveVerdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] t [5] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'hff};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(epAttachedMap, 8'h00);
        acc(3'h1, 1'b0, 1'b0, 32'h0);
        $display("test reset done");
        req(`REQ_TYPE_ATTACH, 8'h5, 8'h1, 8'h0, 8'h0, 20, `STS_OK, 1'b1);
        acc(3'h1, 1'b0, 1'b1, 32'h5);
        req(`REQ_TYPE_ATTACH, 8'h5, 8'h2, 8'h0, 8'h0, 20, `STS_OK, 1'b1);
        req(`REQ_TYPE_ATTACH, 8'h5, 8'h3, 8'h0, 8'h0, 20, `STS_UNSUPP, 1'b1);
        req(`REQ_TYPE_ATTACH, 8'h7, 8'h1, 8'h0, 8'h0, 20, `STS_OK, 1'b1);
        acc(3'h1, 1'b0, 1'b1, 32'h7);
        check(epAttachedMap, 8'h06);
        $display("test attach done");
        req(`REQ_TYPE_ATTACH, 8'h5, 8'h2, 8'h0, 8'h1, 20, `STS_INVAL, 1'b1);
        req(`REQ_TYPE_ATTACH, 8'h5, 8'h2, 8'h2, 8'h0, 20, `STS_INVAL, 1'b1);
        req(`REQ_TYPE_ATTACH, 8'h9, 8'h4, 8'h1, 8'h0, 20, `STS_INVAL, 1'b1);
        req(`REQ_TYPE_ATTACH, 8'h5, 8'h8, 8'h0, 8'h0, 20, `STS_NOENT, 1'b1);
        req(`REQ_TYPE_DETACH, 8'h5, 8'h9, 8'h0, 8'h0, 20, `STS_NOENT, 1'b1);
        featBypassCfg <= 1'b1;
        req(`REQ_TYPE_ATTACH, 8'h7, 8'h2, 8'h1, 8'h0, 20, `STS_INVAL, 1'b1);
        req(`REQ_TYPE_DETACH, 8'h7, 8'h2, 8'h0, 8'h0, 20, `STS_INVAL, 1'b1);
        $display("test errors done");
        req(`REQ_TYPE_ATTACH, 8'h9, 8'h4, 8'h1, 8'h0, 20, `STS_OK, 1'b1);
        acc(3'h4, 1'b1, 1'b0, 32'h0);
        req(`REQ_TYPE_DETACH, 8'h5, 8'h2, ~32'h0, ~32'h0, 20, `STS_OK, 1'b1);
        check(epAttachedMap, 8'h12);
        acc(3'h2, 1'b0, 1'b0, 32'h0);
        req(`REQ_TYPE_ATTACH, 8'h5, 8'h3, 8'h1, 8'h0, 20, `STS_OK, 1'b1);
        acc(3'h3, 1'b1, 1'b0, 32'h0);
        cfgBypass <= 1'b1;
        acc(3'h0, 1'b1, 1'b0, 32'h0);
        cfgBypass        <= 1'b0;
        featBypassLegacy <= 1'b1;
        acc(3'h0, 1'b1, 1'b0, 32'h0);
        featBypassLegacy <= 1'b0;
        $display("test bypass done");
        foreach (t[i]) req(t[i], 8'h6, 8'h5, 8'h0, 8'h0, 20, `STS_OK, 1'b0);
        req(`REQ_TYPE_ATTACH, 8'h6, 8'h5, 8'h0, 8'h0, 10, `STS_OK, 1'b0);
        // A writable part too small for the tail must also leave tables alone
        guest_driver_model_inst.setWrLen(8'h02);
        req(`REQ_TYPE_ATTACH, 8'h6, 8'h5, 8'h0, 8'h0, 20, `STS_OK, 1'b0);
        guest_driver_model_inst.setWrLen(8'h04);
        check(epAttachedMap, 8'h1a);
        $display("test unknown done");
        giveVerdict();
    end
endmodule // test_iommu_attach_detach_handler
